/* File: cplf_fifo.sv */
// Phase error FIFO with valid/ready on both sides.
module cplf_fifo
  import cplf_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = 8
)
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [W-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Drain takes the word
  output logic [W-1:0] out_data, // Oldest word
  output logic [$clog2(DEPTH):0] count // Words held
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("cplf_fifo depth must be a power of two of at least two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } cplf_fifo_t;

  cplf_fifo_t state_reg;
  cplf_fifo_t state_next;
  logic push;
  logic pop;

  assign in_ready = (state_reg.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (state_reg.cnt != '0);
  assign out_data = state_reg.mem[state_reg.rp];
  assign count = state_reg.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    state_next = state_reg;
    if (push)
    begin
      state_next.mem[state_reg.wp] = in_data;
      state_next.wp = state_reg.wp + 1'b1;
    end
    if (pop)
    begin
      state_next.rp = state_reg.rp + 1'b1;
    end
    state_next.cnt = state_reg.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

endmodule

/* File: cplf_map.svh */
// Register map, field positions, reset values and constants of the loop.
`ifndef CPLF_MAP_SVH
`define CPLF_MAP_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define CPLF_A_PED 8'h00
`define CPLF_A_OSEL 8'h04
`define CPLF_A_LOOP 8'h08
`define CPLF_A_LEAD 8'h0c
`define CPLF_A_LAG 8'h10
`define CPLF_A_UPLO 8'h14
`define CPLF_A_UPHI 8'h18
`define CPLF_A_LWLO 8'h1c
`define CPLF_A_LWHI 8'h20
`define CPLF_A_INLO 8'h24
`define CPLF_A_INHI 8'h28
`define CPLF_A_LGLO 8'h2c
`define CPLF_A_LGHI 8'h30
`define CPLF_A_FOUT 8'h34
`define CPLF_A_STAT 8'h38

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define CPLF_PED_OFS 3:0
`define CPLF_PED_SHF 5:4
`define CPLF_OSEL_F 3:0
`define CPLF_LOOP_ACC 0
`define CPLF_LOOP_IND 1
`define CPLF_LOOP_SER 2
`define CPLF_LOOP_INIT 3
`define CPLF_GAIN_M 3:0
`define CPLF_GAIN_E 8:4
`define CPLF_HI_F 7:0

// ----------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------
`define CPLF_SEL_PHERR 4'h1
`define CPLF_UPPER_RST 40'h7f_ffff_ffff
`define CPLF_LOWER_RST 40'h80_0000_0000
`define CPLF_GAIN_ALIGN 5'h04
`define CPLF_SER_LAST 6'h1f

`endif

/* File: cplf_nco_rx.sv */
// Model of the external tuner NCO taking the serial frequency word.
module cplf_nco_rx
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic sdata, // Serial bit
  input wire logic ssync, // First bit marker
  output logic [31:0] word, // Received word
  output logic word_valid // Pulse on full word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [30:0] sh;
  logic [5:0] cnt;
  // A sync in mid-word restarts the count, as the tuner would.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh <= '0;
      cnt <= '0;
      word <= '0;
      word_valid <= 1'b0;
    end
    else
    begin
      word_valid <= 1'b0;
      if (ssync)
      begin
        sh <= {30'h0, sdata};
        cnt <= 6'd1;
      end
      else if (cnt != 6'd0)
      begin
        sh <= {sh[29:0], sdata};
        cnt <= (cnt == 6'd31) ? 6'd0 : cnt + 6'd1;
        if (cnt == 6'd31)
        begin
          word <= {sh, sdata};
          word_valid <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: cplf_pkg.sv */
// Types shared by the carrier phase loop filter modules.
package cplf_pkg;

  // Six-edge processing cycle of the loop filter.
  typedef enum logic [2:0] {
    CPLF_IDLE,
    CPLF_LEAD,
    CPLF_LAGM,
    CPLF_ACCU,
    CPLF_LIMT,
    CPLF_OUTP
  } cplf_step_t;

endpackage

/* File: cplf_top.sv */
// Carrier phase error detector and lead/lag loop filter with APB registers.
`include "cplf_map.svh"

module cplf_top
  import cplf_pkg::*;
#(
  parameter int ACC_W = 16,
  parameter int FIFO_DEPTH = 8
)
(
  input wire logic pclk, // Device clock, 100 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [7:0] phase_in, // Converter phase, one turn = 256
  input wire logic phase_valid, // Converter sample strobe
  output logic phase_ready, // Error FIFO has room
  input wire logic end_symbol, // Sample is an end-symbol sample
  input wire logic carrier_loop_freeze, // Freeze the loop filter
  input wire logic [39:0] afc_term, // AFC filter contribution
  input wire logic [39:0] sweep_term, // Frequency sweep contribution
  output logic [7:0] err_bus_out, // Selected output bus
  output logic [31:0] nco_freq, // On-chip NCO frequency word
  output logic nco_freq_valid, // Pulse on new NCO word
  output logic carrier_freq_serial_out, // Serial frequency bit
  output logic carrier_freq_serial_sync // Pulse on first serial bit
);

  if (ACC_W < 8 || ACC_W > 32 || FIFO_DEPTH > 8) begin : g_bad_acc
    $error("cplf_top accumulator width or FIFO depth out of range");
  end

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] ofs;
    logic [1:0] shf;
    logic [3:0] osel;
    logic acc_en;
    logic ind_sel;
    logic ser_sel;
    logic [8:0] lead_g;
    logic [8:0] lag_g;
    logic [39:0] upper;
    logic [39:0] lower;
    logic [39:0] init;
    logic fz;
    cplf_step_t st;
    logic [ACC_W-1:0] err;
    logic [ACC_W-1:0] acc;
    logic acc_vld;
    logic [39:0] lead_t;
    logic [39:0] lag_t;
    logic [39:0] lag;
    logic [39:0] fout;
    logic [7:0] bus;
    logic [31:0] nco;
    logic nco_vld;
    logic [31:0] ser_sh;
    logic [5:0] ser_cnt;
    logic ser_bit;
    logic ser_sync;
    logic [31:0] rdata;
  } cplf_state_t;

  localparam cplf_state_t RST_VAL = '{
    upper: `CPLF_UPPER_RST,
    lower: `CPLF_LOWER_RST,
    st: CPLF_IDLE,
    default: '0
  };

  cplf_state_t state_reg;
  cplf_state_t state_next;

  logic [7:0] rot;
  logic [7:0] pherr;
  logic push;
  logic f_ovalid;
  logic f_oready;
  logic [7:0] f_odata;
  logic [$clog2(FIFO_DEPTH):0] f_count;
  logic [ACC_W-1:0] f_ext;
  logic [ACC_W-1:0] acc_sum;
  logic take;
  logic [39:0] sum_out;
  logic setup;
  logic wr;
  logic mapped;

  // --------------------------------------------------------------------
  // Phase error detector
  // --------------------------------------------------------------------
  // Adding to the top nibble alone makes the wrap modulo one turn.
  assign rot = {4'(phase_in[7:4] + state_reg.ofs), phase_in[3:0]};
  assign pherr = 8'(rot << state_reg.shf);
  // A sample that finds the FIFO full is lost; phase_ready warns the
  // source, which otherwise cannot be stalled in a live receiver.
  assign push = phase_valid
    && (!state_reg.ind_sel || end_symbol);

  cplf_fifo #(
    .W(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push),
    .in_ready(phase_ready),
    .in_data(pherr),
    .out_valid(f_ovalid),
    .out_ready(f_oready),
    .out_data(f_odata),
    .count(f_count)
  );

  // --------------------------------------------------------------------
  // Loop filter intake
  // --------------------------------------------------------------------
  // Sign bit at 2^0, LSB at 2^-7; the accumulator keeps the same LSB.
  assign f_ext = ACC_W'($signed(f_odata));
  assign acc_sum = state_reg.acc + (f_ovalid ? f_ext : '0);
  // Without the accumulator the FIFO is only drained when the filter is
  // idle, so it fills and excess errors are refused at its input.
  assign take = (state_reg.st == CPLF_IDLE)
    && (f_ovalid || (state_reg.acc_en && state_reg.acc_vld));
  assign f_oready = state_reg.acc_en || (state_reg.st == CPLF_IDLE);

  assign sum_out = state_reg.lag + state_reg.lead_t
    + afc_term + sweep_term;

  // Gain (1 + M/16) * 2^-(32-E) on an error with LSB 2^-7, giving a term
  // with LSB 2^-39: product of error and (16 + M), shifted by E - 4.
  function automatic logic [39:0] gain_term(
    input logic signed [ACC_W-1:0] e,
    input logic [8:0] g
  );
    logic signed [63:0] p;
    logic [4:0] ex;
    ex = g[`CPLF_GAIN_E];
    p = 64'(e) * $signed({59'h0, 1'b1, g[`CPLF_GAIN_M]});
    if (ex >= `CPLF_GAIN_ALIGN)
    begin
      p = p <<< (ex - `CPLF_GAIN_ALIGN);
    end
    else
    begin
      p = p >>> (`CPLF_GAIN_ALIGN - ex);
    end
    return p[39:0];
  endfunction

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;

  always_comb
  begin
    case (paddr)
      `CPLF_A_PED, `CPLF_A_OSEL, `CPLF_A_LOOP, `CPLF_A_LEAD,
      `CPLF_A_LAG, `CPLF_A_UPLO, `CPLF_A_UPHI, `CPLF_A_LWLO,
      `CPLF_A_LWHI, `CPLF_A_INLO, `CPLF_A_INHI, `CPLF_A_LGLO,
      `CPLF_A_LGHI, `CPLF_A_FOUT, `CPLF_A_STAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !mapped;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.nco_vld = 1'b0;
    state_next.fz = carrier_loop_freeze;

    if (phase_valid)
    begin
      state_next.bus = (state_reg.osel == `CPLF_SEL_PHERR)
        ? pherr : 8'h00;
    end

    // Error accumulator sums every popped error until the filter takes it.
    if (take)
    begin
      state_next.err = state_reg.acc_en ? acc_sum : f_ext;
      if (state_reg.fz)
      begin
        state_next.err = '0;
      end
      state_next.acc = '0;
      state_next.acc_vld = 1'b0;
      state_next.st = CPLF_LEAD;
    end
    else if (state_reg.acc_en && f_ovalid)
    begin
      state_next.acc = acc_sum;
      state_next.acc_vld = 1'b1;
    end

    case (state_reg.st)
      CPLF_IDLE:
      begin
      end
      CPLF_LEAD:
      begin
        state_next.lead_t = gain_term(state_reg.err, state_reg.lead_g);
        state_next.st = CPLF_LAGM;
      end
      CPLF_LAGM:
      begin
        state_next.lag_t = gain_term(state_reg.err, state_reg.lag_g);
        state_next.st = CPLF_ACCU;
      end
      CPLF_ACCU:
      begin
        state_next.lag = state_reg.lag + state_reg.lag_t;
        state_next.st = CPLF_LIMT;
      end
      CPLF_LIMT:
      begin
        if ($signed(state_reg.lag) > $signed(state_reg.upper))
        begin
          state_next.lag = state_reg.upper;
        end
        else if ($signed(state_reg.lag) < $signed(state_reg.lower))
        begin
          state_next.lag = state_reg.lower;
        end
        state_next.st = CPLF_OUTP;
      end
      CPLF_OUTP:
      begin
        state_next.fout = sum_out;
        if (!state_reg.ser_sel)
        begin
          state_next.nco = sum_out[39:8];
          state_next.nco_vld = 1'b1;
        end
        state_next.st = CPLF_IDLE;
      end
      default:
      begin
        state_next.st = CPLF_IDLE;
      end
    endcase

    // Serial word goes MSB first; a word finishing mid-shift is skipped
    // and nothing is sent until the next filter output after the shift ends.
    if (state_reg.ser_cnt != '0)
    begin
      state_next.ser_bit = state_reg.ser_sh[31];
      state_next.ser_sh = {state_reg.ser_sh[30:0], 1'b0};
      state_next.ser_cnt = state_reg.ser_cnt - 1'b1;
      state_next.ser_sync = 1'b0;
    end
    else if (state_reg.ser_sel && state_reg.st == CPLF_OUTP)
    begin
      state_next.ser_bit = sum_out[39];
      state_next.ser_sh = {sum_out[38:8], 1'b0};
      state_next.ser_cnt = `CPLF_SER_LAST;
      state_next.ser_sync = 1'b1;
    end
    else
    begin
      state_next.ser_bit = 1'b0;
      state_next.ser_sync = 1'b0;
    end

    // Read data is captured in the setup cycle and stands in the access.
    if (setup)
    begin
      case (paddr)
        `CPLF_A_PED: state_next.rdata = {26'h0,
          state_reg.shf, state_reg.ofs};
        `CPLF_A_OSEL: state_next.rdata = {28'h0, state_reg.osel};
        `CPLF_A_LOOP: state_next.rdata = {29'h0, state_reg.ser_sel,
          state_reg.ind_sel, state_reg.acc_en};
        `CPLF_A_LEAD: state_next.rdata = {23'h0, state_reg.lead_g};
        `CPLF_A_LAG: state_next.rdata = {23'h0, state_reg.lag_g};
        `CPLF_A_UPLO: state_next.rdata = state_reg.upper[31:0];
        `CPLF_A_UPHI: state_next.rdata = {24'h0, state_reg.upper[39:32]};
        `CPLF_A_LWLO: state_next.rdata = state_reg.lower[31:0];
        `CPLF_A_LWHI: state_next.rdata = {24'h0, state_reg.lower[39:32]};
        `CPLF_A_INLO: state_next.rdata = state_reg.init[31:0];
        `CPLF_A_INHI: state_next.rdata = {24'h0, state_reg.init[39:32]};
        `CPLF_A_LGLO: state_next.rdata = state_reg.lag[31:0];
        `CPLF_A_LGHI: state_next.rdata = {24'h0,
          state_reg.lag[39:32]};
        `CPLF_A_FOUT: state_next.rdata = state_reg.fout[39:8];
        `CPLF_A_STAT: state_next.rdata = {24'h0,
          4'(f_count), 2'h0, state_reg.fz,
          state_reg.st != CPLF_IDLE};
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end

    // Writes come last so a lag load wins over a filter update.
    if (wr)
    begin
      case (paddr)
        `CPLF_A_PED:
        begin
          state_next.ofs = pwdata[`CPLF_PED_OFS];
          state_next.shf = pwdata[`CPLF_PED_SHF];
        end
        `CPLF_A_OSEL: state_next.osel = pwdata[`CPLF_OSEL_F];
        `CPLF_A_LOOP:
        begin
          state_next.acc_en = pwdata[`CPLF_LOOP_ACC];
          state_next.ind_sel = pwdata[`CPLF_LOOP_IND];
          state_next.ser_sel = pwdata[`CPLF_LOOP_SER];
          if (pwdata[`CPLF_LOOP_INIT])
          begin
            state_next.lag = state_reg.init;
          end
        end
        `CPLF_A_LEAD: state_next.lead_g = pwdata[8:0];
        `CPLF_A_LAG: state_next.lag_g = pwdata[8:0];
        `CPLF_A_UPLO: state_next.upper[31:0] = pwdata;
        `CPLF_A_UPHI: state_next.upper[39:32] = pwdata[`CPLF_HI_F];
        `CPLF_A_LWLO: state_next.lower[31:0] = pwdata;
        `CPLF_A_LWHI: state_next.lower[39:32] = pwdata[`CPLF_HI_F];
        `CPLF_A_INLO: state_next.init[31:0] = pwdata;
        `CPLF_A_INHI: state_next.init[39:32] = pwdata[`CPLF_HI_F];
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= RST_VAL;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign prdata = state_reg.rdata;
  assign err_bus_out = state_reg.bus;
  assign nco_freq = state_reg.nco;
  assign nco_freq_valid = state_reg.nco_vld;
  assign carrier_freq_serial_out = state_reg.ser_bit;
  assign carrier_freq_serial_sync = state_reg.ser_sync;

endmodule

/* File: cplf_top_sva.sv */
// Port-level checker for the carrier phase loop filter.
`include "cplf_map.svh"

module cplf_top_sva
#(
  parameter int ACC_W = 16,
  parameter int FIFO_DEPTH = 8
)
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic phase_valid, // Sample strobe
  input wire logic [7:0] err_bus_out, // Output bus
  input wire logic [31:0] nco_freq, // NCO word
  input wire logic nco_freq_valid, // NCO word pulse
  input wire logic carrier_freq_serial_sync // Serial sync
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_slverr_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  a_unmapped_err: assert property (psel && penable
    && paddr > `CPLF_A_STAT |-> pslverr)
    else $error("no error on unmapped address");
  a_unmapped_zero: assert property (psel && penable && !pwrite
    && paddr > `CPLF_A_STAT |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property ($changed(prdata)
    |-> $past(psel && !penable))
    else $error("prdata moved outside setup");
  a_bus_cause: assert property ($changed(err_bus_out)
    |-> $past(phase_valid))
    else $error("output bus moved without sample");
  a_filter_space: assert property (nco_freq_valid
    |=> !nco_freq_valid [*5])
    else $error("filter outputs closer than six clocks");
  a_word_pulse: assert property ($changed(nco_freq)
    |-> nco_freq_valid)
    else $error("NCO word moved without pulse");
  a_sync_space: assert property (carrier_freq_serial_sync
    |=> !carrier_freq_serial_sync [*8])
    else $error("serial sync repeated inside frame");
endmodule

bind cplf_top cplf_top_sva #(.ACC_W(ACC_W), .FIFO_DEPTH(FIFO_DEPTH)) i_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .phase_valid(phase_valid),
  .err_bus_out(err_bus_out), .nco_freq(nco_freq),
  .nco_freq_valid(nco_freq_valid),
  .carrier_freq_serial_sync(carrier_freq_serial_sync));

/* File: cplf_top_tb.sv */
// Self-checking testbench of the carrier phase loop filter.
`include "cplf_map.svh"

module cplf_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, phase_in, err_bus_out, lfsr, ph, ph2;
  logic [31:0] pwdata, prdata, nco_freq, rx_word, rd;
  logic phase_valid, phase_ready, end_symbol, carrier_loop_freeze;
  logic nco_freq_valid, ser_out, ser_sync, rx_valid, rd_err;
  logic [39:0] afc_term, sweep_term, lim, fexp;
  logic [31:0] q_nco[$];
  logic [31:0] q_ser[$];
  int n_mismatch, n_tests, k, shf_k, ofs_k;
  cplf_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phase_in(phase_in), .phase_valid(phase_valid),
    .phase_ready(phase_ready), .end_symbol(end_symbol),
    .carrier_loop_freeze(carrier_loop_freeze), .afc_term(afc_term),
    .sweep_term(sweep_term), .err_bus_out(err_bus_out),
    .nco_freq(nco_freq), .nco_freq_valid(nco_freq_valid),
    .carrier_freq_serial_out(ser_out),
    .carrier_freq_serial_sync(ser_sync));
  cplf_nco_rx i_rx (.pclk(pclk), .presetn(presetn), .sdata(ser_out),
    .ssync(ser_sync), .word(rx_word), .word_valid(rx_valid));
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr40(input logic [7:0] a, input logic [39:0] v);
    apb(1'b1, a, v[31:0]);
    apb(1'b1, a + 8'h04, {24'h0, v[39:32]});
  endtask
  task automatic smp(input logic [7:0] p, input logic es);
    @(posedge pclk);
    phase_in <= p;
    end_symbol <= es;
    phase_valid <= 1'b1;
    @(posedge pclk);
    phase_valid <= 1'b0;
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Result watchers
  // ------------------------------------------------------------------
  always @(posedge pclk)
  begin
    if (nco_freq_valid === 1'b1 && q_nco.size() > 0)
      chk("nco_freq", q_nco.pop_front(), nco_freq);
    if (rx_valid === 1'b1 && q_ser.size() > 0)
      chk("serial_word", q_ser.pop_front(), rx_word);
  end
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    summarize();
  end
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, phase_valid, end_symbol} = '0;
    {paddr, pwdata, phase_in, carrier_loop_freeze} = '0;
    {afc_term, sweep_term} = '0;
    lfsr = 8'd52;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CPLF_A_UPHI, 0);
    chk("upper_hi", 32'h0000_007f, rd);
    apb(1'b0, `CPLF_A_LWHI, 0);
    chk("lower_hi", 32'h0000_0080, rd);
    apb(1'b0, 8'h3c, 0);
    chk("unmapped", 32'h0000_0001, {rd[30:0], rd_err});
    // Offset and shift per modulation: CW, BPSK, QPSK, 8-PSK.
    apb(1'b1, `CPLF_A_OSEL, `CPLF_SEL_PHERR);
    for (k = 0; k < 12; k++)
    begin
      shf_k = k / 3;
      ofs_k = k / 6 * (4 - shf_k);
      apb(1'b1, `CPLF_A_PED, {26'h0, 2'(shf_k), 4'(ofs_k)});
      ph = rnd();
      smp(ph, 1'b0);
      #1 chk("err_bus_out", {24'h0, {ph[7:4] + 4'(ofs_k),
        ph[3:0]} << shf_k}, {24'h0, err_bus_out});
      repeat (6) @(posedge pclk);
    end
    apb(1'b1, `CPLF_A_OSEL, 32'h0000_0000);
    smp(rnd(), 1'b0);
    #1 chk("err_bus_off", 32'h0000_0000, {24'h0, err_bus_out});
    @(posedge pclk);
    // Freeze: the error is nulled, so only the lag and the sums remain.
    afc_term <= {rnd(), rnd(), rnd(), 16'h0};
    sweep_term <= {32'h0, rnd()};
    carrier_loop_freeze <= 1'b1;
    repeat (20) @(posedge pclk);
    lim = {rnd(), rnd(), 24'h12_3400};
    wr40(`CPLF_A_INLO, lim);
    apb(1'b1, `CPLF_A_LOOP, 32'h0000_0008);
    fexp = lim + afc_term + sweep_term;
    q_nco.push_back(fexp[39:8]);
    smp(8'h55, 1'b0);
    repeat (12) @(posedge pclk);
    apb(1'b0, `CPLF_A_LGHI, 0);
    chk("lag_hi", {24'h0, lim[39:32]}, rd);
    // Lead path with equal limits, so the clamp pins the lag.
    carrier_loop_freeze <= 1'b0;
    lim = {rnd(), rnd(), 24'h00_0100};
    wr40(`CPLF_A_UPLO, lim);
    wr40(`CPLF_A_LWLO, lim);
    apb(1'b1, `CPLF_A_LEAD, 32'h0000_0065);
    apb(1'b1, `CPLF_A_PED, 32'h0000_0000);
    smp(rnd(), 1'b0);
    repeat (12) @(posedge pclk);
    apb(1'b1, `CPLF_A_LOOP, 32'h0000_0004);
    ph = rnd();
    fexp = lim + ({{32{ph[7]}}, ph} * 40'd21 << 2) + afc_term + sweep_term;
    q_ser.push_back(fexp[39:8]);
    smp(ph, 1'b0);
    repeat (50) @(posedge pclk);
    apb(1'b0, `CPLF_A_LGLO, 0);
    chk("lag_lo", lim[31:0], rd);
    apb(1'b0, `CPLF_A_FOUT, 0);
    chk("fout", fexp[39:8], rd);
    // Integrate-and-dump: only end-symbol samples reach the filter.
    apb(1'b1, `CPLF_A_LOOP, 32'h0000_0002);
    smp(rnd(), 1'b0);
    apb(1'b0, `CPLF_A_STAT, 0);
    chk("busy", 32'h0000_0000, {31'h0, rd[0]});
    ph = rnd();
    fexp = lim + ({{32{ph[7]}}, ph} * 40'd21 << 2) + afc_term + sweep_term;
    q_nco.push_back(fexp[39:8]);
    smp(ph, 1'b1);
    repeat (12) @(posedge pclk);
    // Error accumulator: errors arriving while the filter is busy add up.
    apb(1'b1, `CPLF_A_LOOP, 32'h0000_0001);
    ph = rnd();
    fexp = lim + ({{32{ph[7]}}, ph} * 40'd21 << 2) + afc_term + sweep_term;
    q_nco.push_back(fexp[39:8]);
    smp(ph, 1'b0);
    ph = rnd();
    ph2 = rnd();
    fexp = ({{32{ph[7]}}, ph} + {{32{ph2[7]}}, ph2}) * 40'd21 << 2;
    fexp = fexp + lim + afc_term + sweep_term;
    q_nco.push_back(fexp[39:8]);
    smp(ph, 1'b0);
    smp(ph2, 1'b0);
    repeat (20) @(posedge pclk);
    // Fill the error FIFO until it refuses, then let it drain.
    apb(1'b1, `CPLF_A_LOOP, 32'h0000_0000);
    k = 0;
    @(posedge pclk);
    phase_valid <= 1'b1;
    while (phase_ready === 1'b1 && k < 16)
    begin
      @(posedge pclk);
      phase_in <= rnd();
      k++;
    end
    phase_valid <= 1'b0;
    chk("phase_ready", 32'h0000_0000, {31'h0, phase_ready});
    repeat (120) @(posedge pclk);
    apb(1'b0, `CPLF_A_STAT, 0);
    chk("fifo_count", 32'h0000_0000, {28'h0, rd[7:4]});
    chk("queues", 32'h0000_0000, q_nco.size() + q_ser.size());
    summarize();
  end
endmodule
